// ---- inc/dma_pkg.sv ----
/*
 * shared constants and types for the offset-add repeat dma channel.
 * assumes one 25 mhz clock and byte addresses on a 24-bit space.
 */
package dma_pkg;
  localparam int ADDR_W = 24;
  // register byte addresses
  localparam logic [23:0] ADR_SRC  = 24'hfffc00;
  localparam logic [23:0] ADR_DST  = 24'hfffc04;
  localparam logic [23:0] ADR_OFS  = 24'hfffc08;
  localparam logic [23:0] ADR_CNT  = 24'hfffc0c;
  localparam logic [23:0] ADR_RSZ  = 24'hfffc10;
  localparam logic [23:0] ADR_MODE = 24'hfffc14;
  localparam logic [23:0] ADR_ACTL = 24'hfffc18;
  localparam logic [23:0] ADR_STAT = 24'hfffc1c;
  localparam logic [23:0] ADR_MASK = 24'hfffc20;
  // mode control fields
  localparam int MD_TE   = 31;
  localparam int MD_NRD  = 26;
  localparam int MD_CEF  = 16;
  localparam int MD_SZ   = 14;
  localparam int MD_MODE = 12;
  localparam int MD_ESCAPE_IRQ_ENABLE = 9;
  localparam int MD_FACT = 6;
  localparam logic [31:0] MODE_WMASK = 32'h8400_f2c0;
  // address control fields
  localparam int AC_AMS   = 31;
  localparam int AC_REPEAT_END_IRQ_ENABLE = 26;
  localparam int AC_ARS   = 24;
  localparam int AC_SAT   = 20;
  localparam int AC_DAT   = 16;
  localparam logic [31:0] ACTL_WMASK = 32'h8733_0000;
  // field encodings
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] MODE_RPT  = 2'h0;
  localparam logic [1:0] FACT_AUTO = 2'h0;
  localparam logic [1:0] ARS_SRC   = 2'h0;
  localparam logic [1:0] UPD_FIX   = 2'h0;
  localparam logic [1:0] UPD_OFS   = 2'h1;
  localparam logic [1:0] UPD_INC   = 2'h2;
  localparam logic [1:0] UPD_DEC   = 2'h3;
  localparam logic [31:0] BYTE_STEP = 32'h1;
  // interrupt status bits
  localparam int ST_CEND = 0;
  localparam int ST_ESC  = 1;
  localparam int ST_W    = 2;
  localparam logic [31:0] REG_RST  = 32'h0;
  localparam logic [ST_W-1:0] MASK_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NRD_GAP_CYC = 1;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUSY = 2'b01,
    S_GAP  = 2'b10
  } chan_state_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_RD   = 2'b01,
    M_WR   = 2'b10
  } mover_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic              single;
  } xfer_job_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              we;
    logic [7:0]        wdata;
  } mem_req_t;
endpackage

// ---- rtl/dma_byte_mover.sv ----
/*
 * one byte transfer on the memory bus: read source, then write dest; single address mode reads only.
 * assumes memory pulses i_mem_ack once per access while o_mem_req is high.
 */
module dma_byte_mover
  import dma_pkg::*;
(
  input  wire logic      i_clk,       // system clock
  input  wire logic      i_rst,       // async reset, high
  input  wire logic      i_start,     // one-cycle start
  input  wire xfer_job_t i_job,       // addresses and method
  input  wire logic      i_mem_ack,   // access finished
  input  wire logic [7:0] i_mem_rdata, // read data
  output logic           o_mem_req,   // access under way
  output mem_req_t       o_mem,       // address, direction, data
  output logic           o_done       // one-cycle end pulse
);
  mover_state_t st_r;
  logic [ADDR_W-1:0] dst_r;
  logic wr_phase;

  // single address mode needs no write access
  assign wr_phase = (st_r == M_RD) & i_mem_ack;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r      <= M_IDLE;
      dst_r     <= '0;
      o_mem_req <= 1'b0;
      o_mem     <= '0;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (st_r)
        M_IDLE: begin
          if (i_start) begin
            st_r      <= M_RD;
            dst_r     <= i_job.dst;
            o_mem_req <= 1'b1;
            o_mem     <= '{addr: i_job.src, we: 1'b0, wdata: 8'h00};
            if (i_job.single) begin
              dst_r <= '0;
            end
          end
        end
        M_RD: begin
          if (wr_phase && dst_r == '0 && o_mem.we == 1'b0
              && o_mem_req && st_r == M_RD && i_job.single) begin
            st_r      <= M_IDLE;
            o_mem_req <= 1'b0;
            o_done    <= 1'b1;
          end else if (wr_phase) begin
            st_r  <= M_WR;
            o_mem <= '{addr: dst_r, we: 1'b1, wdata: i_mem_rdata};
          end
        end
        M_WR: begin
          if (i_mem_ack) begin
            st_r      <= M_IDLE;
            o_mem_req <= 1'b0;
            o_done    <= 1'b1;
          end
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/dma_channel_offset_repeat.sv ----
/*
 * one dma channel: axi4-lite registers, auto-request cycle stealing,
 * repeat mode with offset-add source and incrementing destination.
 * assumes a byte-wide memory bus with ack handshake; one clock domain.
 */
// Design decision made here: the AXI4-Lite slave port.
// Operation
// - transfers only while transfer enable is set
// - next-request delay adds one idle cycle
// - count end flag cleared by write-0-after-read
// - access size 00 means byte transfers
// - transfer mode 00 selects repeat mode
// - escape irq enable gates escape end interrupt
// - start factor 00 means auto request
// - address method bit picks dual or single
// - repeat end irq enable gates repeat end
// - area select 00 makes source repeat area
// - source update 01 adds offset register
// - destination update 10 increments by one
// - offset register holds the added value
// - count register decrements per transfer
// - repeat size register gives repeat length
module dma_channel_offset_repeat
  import dma_pkg::*;
(
  input  wire logic        i_clk,       // 25 mhz system clock
  input  wire logic        i_rst,       // async reset, high
  input  wire logic        i_awvalid,   // write address valid
  output logic             o_awready,   // write address ready
  input  wire logic [23:0] i_awaddr,    // write byte address
  input  wire logic        i_wvalid,    // write data valid
  output logic             o_wready,    // write data ready
  input  wire logic [31:0] i_wdata,     // write data
  input  wire logic [3:0]  i_wstrb,     // byte enables
  output logic             o_bvalid,    // write response valid
  input  wire logic        i_bready,    // write response ready
  output logic [1:0]       o_bresp,     // write response
  input  wire logic        i_arvalid,   // read address valid
  output logic             o_arready,   // read address ready
  input  wire logic [23:0] i_araddr,    // read byte address
  output logic             o_rvalid,    // read data valid
  input  wire logic        i_rready,    // read data ready
  output logic [31:0]      o_rdata,     // read data
  output logic [1:0]       o_rresp,     // read response
  input  wire logic        i_mem_ack,   // memory access done
  input  wire logic [7:0]  i_mem_rdata, // memory read byte
  output logic             o_mem_req,   // memory access request
  output mem_req_t         o_mem,       // memory address and data
  output logic             o_irq        // level interrupt
);
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus slave state
  logic        aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic [23:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r;
  logic        arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // channel registers
  logic [31:0] src_r, dst_r, ofs_r, cnt_r, rsz_r, mode_r, actl_r;
  logic [31:0] src_nxt, dst_nxt, cnt_nxt, rsz_nxt, mode_nxt;
  logic [31:0] src_base_r;
  logic [ST_W-1:0] stat_r, stat_nxt, mask_r;
  logic        cef_seen_r, irq_r;
  chan_state_t st_r, st_nxt;
  logic        mv_done;

  // write side decode
  wire aw_take = i_awvalid & awready_r;
  wire w_take  = i_wvalid & wready_r;
  wire aw_have = aw_have_r | aw_take;
  wire w_have  = w_have_r | w_take;
  wire wr_go   = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_src  = wr_go & (aw_addr_r == ADR_SRC);
  wire wr_dst  = wr_go & (aw_addr_r == ADR_DST);
  wire wr_ofs  = wr_go & (aw_addr_r == ADR_OFS);
  wire wr_cnt  = wr_go & (aw_addr_r == ADR_CNT);
  wire wr_rsz  = wr_go & (aw_addr_r == ADR_RSZ);
  wire wr_mode = wr_go & (aw_addr_r == ADR_MODE);
  wire wr_actl = wr_go & (aw_addr_r == ADR_ACTL);
  wire wr_stat = wr_go & (aw_addr_r == ADR_STAT);
  wire wr_mask = wr_go & (aw_addr_r == ADR_MASK);
  wire wr_hit  = wr_src | wr_dst | wr_ofs | wr_cnt | wr_rsz | wr_mode
                 | wr_actl | wr_stat | wr_mask;
  wire bvalid_nxt = wr_go | (bvalid_r & ~i_bready);
  wire aw_have_nxt = aw_have & ~wr_go;
  wire w_have_nxt  = w_have & ~wr_go;

  // read side decode
  wire ar_go   = i_arvalid & arready_r;
  wire rd_mode = ar_go & (i_araddr == ADR_MODE);
  wire rd_stat = ar_go & (i_araddr == ADR_STAT);
  wire rd_hit  = (i_araddr >= ADR_SRC) & (i_araddr <= ADR_MASK)
                 & (i_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux =
      (i_araddr == ADR_SRC)  ? src_r  :
      (i_araddr == ADR_DST)  ? dst_r  :
      (i_araddr == ADR_OFS)  ? ofs_r  :
      (i_araddr == ADR_CNT)  ? cnt_r  :
      (i_araddr == ADR_RSZ)  ? rsz_r  :
      (i_araddr == ADR_MODE) ? mode_r :
      (i_araddr == ADR_ACTL) ? actl_r :
      (i_araddr == ADR_STAT) ? {{(32-ST_W){1'b0}}, stat_r} :
      (i_araddr == ADR_MASK) ? {{(32-ST_W){1'b0}}, mask_r} : 32'h0;
  wire rvalid_nxt = ar_go | (rvalid_r & ~i_rready);

  // field views
  wire       te    = mode_r[MD_TE];
  wire       next_request_delay   = mode_r[MD_NRD];
  wire [1:0] sz    = mode_r[MD_SZ +: 2];
  wire [1:0] mds   = mode_r[MD_MODE +: 2];
  wire       escape_irq_enable  = mode_r[MD_ESCAPE_IRQ_ENABLE];
  wire [1:0] fact  = mode_r[MD_FACT +: 2];
  wire       address_method_select   = actl_r[AC_AMS];
  wire       repeat_end_irq_enable = actl_r[AC_REPEAT_END_IRQ_ENABLE];
  wire [1:0] ars   = actl_r[AC_ARS +: 2];
  wire [1:0] sat   = actl_r[AC_SAT +: 2];
  wire [1:0] dat   = actl_r[AC_DAT +: 2];

  // channel control
  wire go = te & (fact == FACT_AUTO) & (sz == SZ_BYTE)
            & (cnt_r != REG_RST);
  wire start    = (st_r == S_IDLE) & go;
  wire rpt_on   = (mds == MODE_RPT);
  wire cnt_last = mv_done & (cnt_r == BYTE_STEP);
  wire rpt_end  = mv_done & rpt_on
                  & (rsz_r[15:0] == BYTE_STEP[15:0]);
  wire rpt_stop = rpt_end & repeat_end_irq_enable;
  wire stop     = cnt_last | rpt_stop;
  wire esc_set  = rpt_stop & escape_irq_enable;
  wire src_wrap = rpt_end & ~repeat_end_irq_enable & (ars == ARS_SRC);
  wire cef_clr  = wr_mode & wstrb_r[MD_CEF/8]
                  & ~wdata_r[MD_CEF] & cef_seen_r;
  wire [ST_W-1:0] stat_set = {esc_set, cnt_last};
  wire [ST_W-1:0] stat_keep =
      wr_stat ? (stat_r & ~wdata_r[ST_W-1:0]) : stat_r;

  xfer_job_t job;
  assign job = '{src: src_r[ADDR_W-1:0], dst: dst_r[ADDR_W-1:0],
                 single: address_method_select};

  dma_byte_mover u_mover (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_start     (start),
    .i_job       (job),
    .i_mem_ack   (i_mem_ack),
    .i_mem_rdata (i_mem_rdata),
    .o_mem_req   (o_mem_req),
    .o_mem       (o_mem),
    .o_done      (mv_done)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (start) begin
          st_nxt = S_BUSY;
        end
      end
      S_BUSY: begin
        if (mv_done) begin
          st_nxt = next_request_delay ? S_GAP : S_IDLE;
        end
      end
      S_GAP: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // address, count and repeat updates; software write wins
  always_comb begin
    src_nxt = src_r;
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    rsz_nxt = rsz_r;
    if (mv_done) begin
      case (sat)
        UPD_OFS: src_nxt = src_r + ofs_r;
        UPD_INC: src_nxt = src_r + BYTE_STEP;
        UPD_DEC: src_nxt = src_r - BYTE_STEP;
        default: src_nxt = src_r;
      endcase
      case (dat)
        UPD_INC: dst_nxt = dst_r + BYTE_STEP;
        UPD_OFS: dst_nxt = dst_r + ofs_r;
        UPD_DEC: dst_nxt = dst_r - BYTE_STEP;
        default: dst_nxt = dst_r;
      endcase
      cnt_nxt = cnt_r - BYTE_STEP;
      if (rpt_on) begin
        rsz_nxt[15:0] = rpt_end ? rsz_r[31:16]
                        : rsz_r[15:0] - BYTE_STEP[15:0];
      end
      if (src_wrap) begin
        src_nxt = src_base_r;
      end
    end
    if (wr_src) begin
      src_nxt = merge(src_r, wdata_r, wstrb_r);
    end
    if (wr_dst) begin
      dst_nxt = merge(dst_r, wdata_r, wstrb_r);
    end
    if (wr_cnt) begin
      cnt_nxt = merge(cnt_r, wdata_r, wstrb_r);
    end
    if (wr_rsz) begin
      rsz_nxt = merge(rsz_r, wdata_r, wstrb_r);
    end
  end

  // mode register: hardware set of the end flag beats the clear
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = (merge(mode_r, wdata_r, wstrb_r) & MODE_WMASK)
                 | (mode_r & ~MODE_WMASK);
    end
    if (cef_clr) begin
      mode_nxt[MD_CEF] = 1'b0;
    end
    if (stop) begin
      mode_nxt[MD_TE] = 1'b0;
    end
    if (cnt_last) begin
      mode_nxt[MD_CEF] = 1'b1;
    end
  end

  // read clears status; a same-cycle event still lands
  assign stat_nxt = (rd_stat ? '0 : stat_keep) | stat_set;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= '0;
      wdata_r   <= REG_RST;
      wstrb_r   <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r  <= ~w_have_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= i_awaddr;
      end
      if (w_take) begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (wr_go) begin
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= REG_RST;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_go) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= S_IDLE;
      src_r  <= REG_RST;
      dst_r  <= REG_RST;
      ofs_r  <= REG_RST;
      cnt_r  <= REG_RST;
      rsz_r  <= REG_RST;
      mode_r <= REG_RST;
      actl_r <= REG_RST;
      src_base_r <= REG_RST;
    end else begin
      st_r   <= st_nxt;
      src_r  <= src_nxt;
      dst_r  <= dst_nxt;
      cnt_r  <= cnt_nxt;
      rsz_r  <= rsz_nxt;
      mode_r <= mode_nxt;
      if (wr_src) begin
        src_base_r <= src_nxt;
      end
      if (wr_ofs) begin
        ofs_r <= merge(ofs_r, wdata_r, wstrb_r);
      end
      if (wr_actl) begin
        actl_r <= merge(actl_r, wdata_r, wstrb_r) & ACTL_WMASK;
      end
    end
  end

  // end flag may only be cleared after software has seen it set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cef_seen_r <= 1'b0;
      stat_r     <= '0;
      mask_r     <= MASK_RST;
      irq_r      <= 1'b0;
    end else begin
      if (rd_mode && mode_r[MD_CEF]) begin
        cef_seen_r <= 1'b1;
      end else if (!mode_nxt[MD_CEF]) begin
        cef_seen_r <= 1'b0;
      end
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= wdata_r[ST_W-1:0];
      end
      irq_r <= |(stat_nxt & (wr_mask ? wdata_r[ST_W-1:0] : mask_r));
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;
  assign o_irq     = irq_r;

  property p_te_gate;
    @(posedge i_clk) disable iff (i_rst)
      start |-> te && fact == FACT_AUTO;
  endproperty
  a_te_gate: assert property (p_te_gate)
    else $error("transfer started while disabled");

  property p_nrd_gap;
    @(posedge i_clk) disable iff (i_rst)
      (st_r == S_BUSY && mv_done && next_request_delay)
        |=> st_r == S_GAP && !o_mem_req ##1 !o_mem_req;
  endproperty
  a_nrd_gap: assert property (p_nrd_gap)
    else $error("next request delay not applied");

  property p_cef_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (mode_r[MD_CEF] && wr_mode && wdata_r[MD_CEF]) |=> mode_r[MD_CEF];
  endproperty
  a_cef_sticky: assert property (p_cef_sticky)
    else $error("end flag cleared by writing one");

  property p_byte_only;
    @(posedge i_clk) disable iff (i_rst)
      o_mem_req && !$past(o_mem_req) |-> $past(sz) == SZ_BYTE;
  endproperty
  a_byte_only: assert property (p_byte_only)
    else $error("access with non-byte size");

  property p_count_end;
    @(posedge i_clk) disable iff (i_rst)
      cnt_last && !wr_mode |=> mode_r[MD_CEF] && !te && stat_r[ST_CEND];
  endproperty
  a_count_end: assert property (p_count_end)
    else $error("count end did not stop and flag");

  property p_esc_gate;
    @(posedge i_clk) disable iff (i_rst)
      (rpt_end && !escape_irq_enable && !stat_r[ST_ESC]) |=> !stat_r[ST_ESC];
  endproperty
  a_esc_gate: assert property (p_esc_gate)
    else $error("escape interrupt raised while disabled");

  property p_rpt_stop;
    @(posedge i_clk) disable iff (i_rst)
      rpt_stop && !wr_mode |=> !te ##1 !o_mem_req [*2];
  endproperty
  a_rpt_stop: assert property (p_rpt_stop)
    else $error("channel kept running after repeat end");

  property p_src_ofs;
    @(posedge i_clk) disable iff (i_rst)
      (mv_done && sat == UPD_OFS && !src_wrap && !wr_src)
        |=> src_r == $past(src_r) + $past(ofs_r);
  endproperty
  a_src_ofs: assert property (p_src_ofs)
    else $error("source not advanced by offset");

  property p_dst_inc;
    @(posedge i_clk) disable iff (i_rst)
      (mv_done && dat == UPD_INC && !wr_dst)
        |=> dst_r == $past(dst_r) + BYTE_STEP;
  endproperty
  a_dst_inc: assert property (p_dst_inc)
    else $error("destination not incremented by one");

  property p_irq_level;
    @(posedge i_clk) disable iff (i_rst)
      o_irq == |(stat_r & mask_r);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status");
endmodule

// ---- bench/mem_model.sv ----
/*
 * byte memory behind the dma channel: acks each access after i_dly
 * cycles. assumes the access stays stable until its ack.
 */
module mem_model
  import dma_pkg::*;
(
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst,   // async reset, high
  input  wire logic       i_req,   // access under way
  input  wire mem_req_t   i_mem,   // access detail
  input  wire logic [3:0] i_dly,   // wait cycles per access
  output logic            o_ack,   // one-cycle access end
  output logic [7:0]      o_rdata  // read byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r   <= 4'h0;
      o_ack   <= 1'b0;
      o_rdata <= 8'h00;
    end else if (i_req && !o_ack && cnt_r >= i_dly) begin
      cnt_r   <= 4'h0;
      o_ack   <= 1'b1;
      o_rdata <= i_mem.addr[7:0] ^ 8'ha5;
    end else begin
      cnt_r   <= (i_req && !o_ack) ? cnt_r + 4'h1 : 4'h0;
      o_ack   <= 1'b0;
      // released data never keeps the last byte
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ---- bench/dma_channel_offset_repeat_test.sv ----
/*
 * self-checking bench for the offset-add repeat dma channel.
 * assumes the channel's axi4-lite slave and byte memory handshake.
 */
module dma_channel_offset_repeat_test
  import dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk, i_rst, i_awvalid, i_wvalid, i_bready;
  logic        i_arvalid, i_rready, i_mem_ack, req_d;
  logic [23:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb, dly;
  logic [7:0]  i_mem_rdata;
  logic [1:0]  o_bresp, o_rresp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_mem_req, o_irq;
  mem_req_t    o_mem;
  mem_req_t    acc_q[$];
  int          num_errors, total_checks, cyc, last_ack, gap;

  dma_channel_offset_repeat u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .o_mem_req(o_mem_req), .o_mem(o_mem), .o_irq(o_irq));

  mem_model u_mem (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(o_mem_req), .i_mem(o_mem),
    .i_dly(dly), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // log every finished access and the gap before each new request
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (o_mem_req && i_mem_ack) begin
      acc_q.push_back(o_mem);
      last_ack = cyc;
    end
    if (o_mem_req && !req_d) gap = cyc - last_ack;
    req_d = o_mem_req;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tmo();
    num_errors++;
    $display("CHECK FAILED wait expected done seen timeout");
    finish_test();
  endtask

  task automatic wr(logic [23:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        i_bready <= 1'b0;
        chk("bresp", 32'(o_bresp), 32'(RESP_OKAY));
        return;
      end
    end
    tmo();
  endtask

  task automatic rd(logic [23:0] a, logic [31:0] e, string nm,
                    logic [1:0] er = RESP_OKAY);
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        i_rready <= 1'b0;
        chk(nm, o_rdata, e);
        chk("rresp", 32'(o_rresp), 32'(er));
        return;
      end
    end
    tmo();
  endtask

  // k == 0 waits for the interrupt, else for k logged accesses
  task automatic wt(int k);
    for (int n = 0; n < 400; n++) begin
      @(posedge i_clk);
      if (k == 0 ? o_irq === 1'b1 : acc_q.size() >= k) return;
    end
    tmo();
  endtask

  task automatic cfg(logic [31:0] cnt, rsz, actl, md);
    acc_q.delete();
    wr(ADR_SRC, 32'h0000_3000);
    wr(ADR_DST, 32'h0000_0100);
    wr(ADR_OFS, 32'h0000_0004);
    wr(ADR_CNT, cnt);
    wr(ADR_RSZ, rsz);
    wr(ADR_ACTL, actl);
    wr(ADR_MODE, md);
  endtask

  task automatic t_reset();
    rd(ADR_MODE, 32'h0, "mode");
    rd(ADR_ACTL, 32'h0, "actl");
    rd(ADR_CNT, 32'h0, "count");
    rd(24'hfffc24, 32'h0, "unmapped", RESP_SLVERR);
    chk("irq", 32'(o_irq), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_run(bit next_request_delay);
    logic [31:0] md;
    md = 32'h0000_0200 | (32'(next_request_delay) << MD_NRD);
    wr(ADR_MASK, 32'h1);
    // repeat size two: the source wraps back after every second byte
    cfg(32'h3, 32'h0002_0002, 32'h0012_0000, md | 32'h8000_0000);
    wt(0);
    chk("accesses", 32'(acc_q.size()), 32'h6);
    for (int k = 0; k < 3; k++) begin
      chk("rd_addr", 32'(acc_q[2*k].addr),
          32'h3000 + 32'(4 * (k % 2)));
      chk("wr_addr", 32'(acc_q[2*k+1].addr), 32'h100 + 32'(k));
      chk("wr_data", 32'(acc_q[2*k+1].wdata),
          32'(8'(4 * (k % 2)) ^ 8'ha5));
      chk("dir", 32'({acc_q[2*k].we, acc_q[2*k+1].we}), 32'h1);
    end
    chk("gap", 32'(gap), 32'(3 + next_request_delay));
    rd(ADR_SRC, 32'h0000_3004, "src");
    rd(ADR_DST, 32'h0000_0103, "dst");
    rd(ADR_CNT, 32'h0, "count");
    rd(ADR_RSZ, 32'h0002_0001, "rsize");
    // a write of 0 before any read of the flag must not clear it
    wr(ADR_MODE, md);
    rd(ADR_MODE, md | 32'h0001_0000, "flag_held");
    wr(ADR_MODE, md | 32'h0001_0000);
    rd(ADR_MODE, md | 32'h0001_0000, "flag_w1");
    wr(ADR_MODE, md);
    rd(ADR_MODE, md, "flag_clr");
    rd(ADR_STAT, 32'h1, "stat");
    chk("irq_clr", 32'(o_irq), 32'h0);
    $display("test run done");
  endtask

  task automatic t_escape(bit escape_irq_enable);
    logic [31:0] md;
    md = 32'(escape_irq_enable) << MD_ESCAPE_IRQ_ENABLE;
    wr(ADR_MASK, 32'h2);
    cfg(32'ha, 32'h0002_0002, 32'h0412_0000, md | 32'h8000_0000);
    wt(4);
    rd(ADR_MODE, md, "te_stop");
    chk("irq", 32'(o_irq), 32'(escape_irq_enable));
    rd(ADR_STAT, 32'(escape_irq_enable) << 1, "esc_stat");
    chk("xfers", 32'(acc_q.size()), 32'h4);
    wr(ADR_SRC, 32'h0000_3001);
    wr(ADR_MODE, md | 32'h8000_0000);
    wt(8);
    chk("resume", 32'(acc_q[4].addr), 32'h3001);
    rd(ADR_CNT, 32'h6, "count");
    rd(ADR_STAT, 32'(escape_irq_enable) << 1, "esc_stat2");
    $display("test escape done");
  endtask

  task automatic t_nostart();
    logic [31:0] md[3] = '{32'h0, 32'h8000_4000, 32'h8000_0040};
    for (int i = 0; i < 3; i++) begin
      acc_q.delete();
      wr(ADR_CNT, 32'h5);
      wr(ADR_MODE, md[i]);
      repeat (30) @(posedge i_clk);
      chk("idle", 32'(acc_q.size()), 32'h0);
      wr(ADR_MODE, 32'h0);
    end
    $display("test nostart done");
  endtask

  task automatic t_single();
    dly <= 4'h3;
    wr(ADR_MASK, 32'h1);
    cfg(32'h2, 32'h0010_0010, 32'h8012_0000, 32'h8000_0000);
    wt(0);
    chk("accesses", 32'(acc_q.size()), 32'h2);
    chk("single0", 32'({acc_q[0].we, acc_q[0].addr}), 32'h3000);
    chk("single1", 32'({acc_q[1].we, acc_q[1].addr}),
        32'h3004);
    rd(ADR_STAT, 32'h1, "stat");
    dly <= 4'h0;
    $display("test single done");
  endtask

  initial begin
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
    {i_awaddr, i_araddr, i_wdata} = '0;
    {dly, req_d, cyc, last_ack, gap} = '0;
    i_wstrb = 4'hf;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_run(1'b0);
    t_run(1'b1);
    t_escape(1'b1);
    t_escape(1'b0);
    t_nostart();
    t_single();
    finish_test();
  end
endmodule
